// File: hpc_pkg.sv
// shared constants and types of the host port cycle decode ends
package hpc_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int HPC_DATA_W = 16;
	localparam int HPC_FUNC_W = 2;
	localparam int HPC_BE_W = 2;
	localparam int HPC_SYNC_STAGES = 2;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int HPC_CLK_PERIOD_NS = 8;
	// input clock period of the device; local output clock is eight of these
	localparam int HPC_INPUT_CLOCK_PERIOD_NS = 25;
	// quarter clock time is twice the input clock period
	localparam int HPC_TQ_NS = 2 * HPC_INPUT_CLOCK_PERIOD_NS;
	localparam int HPC_SPACING_NS = 7 * HPC_TQ_NS + 10;
	localparam int HPC_STROBE_LOW_NS = 80;
	localparam int HPC_STROBE_HIGH_NS = 60;
	localparam int HPC_RDY_HOLD_NS = 40;
	localparam int HPC_SETUP_NS = 10;
	localparam int HPC_FUNC_HOLD_NS = 10;
	// least times round up to whole cycles
	localparam int HPC_SPACING_CYC = (HPC_SPACING_NS + HPC_CLK_PERIOD_NS - 1) / HPC_CLK_PERIOD_NS;
	localparam int HPC_STROBE_LOW_CYC =
		(HPC_STROBE_LOW_NS + HPC_CLK_PERIOD_NS - 1) / HPC_CLK_PERIOD_NS;
	localparam int HPC_STROBE_HIGH_CYC =
		(HPC_STROBE_HIGH_NS + HPC_CLK_PERIOD_NS - 1) / HPC_CLK_PERIOD_NS;
	localparam int HPC_RDY_HOLD_CYC = (HPC_RDY_HOLD_NS + HPC_CLK_PERIOD_NS - 1) / HPC_CLK_PERIOD_NS;
	localparam int HPC_SETUP_CYC = (HPC_SETUP_NS + HPC_CLK_PERIOD_NS - 1) / HPC_CLK_PERIOD_NS;
	localparam int HPC_FUNC_HOLD_CYC = (HPC_FUNC_HOLD_NS + HPC_CLK_PERIOD_NS - 1) / HPC_CLK_PERIOD_NS;
	localparam int HPC_CNT_W = 8;

	// ----------------------------------------------------------------
	// state machines
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HPC_DEV_IDLE = 2'h0,
		HPC_DEV_WAIT = 2'h1,
		HPC_DEV_DONE = 2'h3
	} hpc_dev_state_e;

	typedef enum logic [2:0] {
		HPC_HST_IDLE = 3'h0,
		HPC_HST_SETUP = 3'h1,
		HPC_HST_STROBE = 3'h3,
		HPC_HST_HOLD = 3'h2,
		HPC_HST_GAP = 3'h6
	} hpc_hst_state_e;

endpackage

// File: hpc_if.sv
// pin bundle between the external host and the device host port
`timescale 1ns/100ps
`default_nettype none
interface hpc_if
	import hpc_pkg::*;
#(
	parameter int DATA_W = HPC_DATA_W
);
	logic host_chip_select_n;
	logic host_read_req_n;
	logic host_write_req_n;
	logic host_low_byte_strobe_n;
	logic host_high_byte_strobe_n;
	logic host_func_sel_0;
	logic host_func_sel_1;
	logic host_ready_out;
	logic [DATA_W-1:0] host_data_out;
	logic host_data_oe;
	logic [DATA_W-1:0] dev_data_out;
	logic dev_data_oe;
	logic [DATA_W-1:0] data_level;

	// undriven bus reads as pulled up
	assign data_level = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : '1);

	modport dev (
		input host_chip_select_n,
		input host_read_req_n,
		input host_write_req_n,
		input host_low_byte_strobe_n,
		input host_high_byte_strobe_n,
		input host_func_sel_0,
		input host_func_sel_1,
		output host_ready_out,
		output dev_data_out,
		output dev_data_oe,
		input data_level
	);

	modport host (
		output host_chip_select_n,
		output host_read_req_n,
		output host_write_req_n,
		output host_low_byte_strobe_n,
		output host_high_byte_strobe_n,
		output host_func_sel_0,
		output host_func_sel_1,
		input host_ready_out,
		output host_data_out,
		output host_data_oe,
		input data_level
	);
endinterface
`default_nettype wire

// File: hpc_host.sv
// external host end: runs one bus access per command on the host port pins
`timescale 1ns/100ps
`default_nettype none
module hpc_host
	import hpc_pkg::*;
#(
	parameter int DATA_W = HPC_DATA_W
)(
	input wire logic clk_sys,
	input wire logic rst_b,
	hpc_if.host port,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [HPC_FUNC_W-1:0] cmd_func,
	input wire logic [HPC_BE_W-1:0] cmd_be,
	input wire logic [DATA_W-1:0] cmd_wdata,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata
);
	initial
	begin
		if (DATA_W < 8 || DATA_W % 8 != 0)
			$error("hpc_host: DATA_W must be a whole number of bytes");
	end

	hpc_hst_state_e state_q;
	logic [HPC_CNT_W-1:0] cnt_q;
	logic [HPC_CNT_W-1:0] gap_q;
	logic write_q;
	logic [HPC_BE_W-1:0] be_q;
	logic [HPC_FUNC_W-1:0] func_q;
	logic [DATA_W-1:0] wdata_q;
	logic strobe_q;
	logic rdy_meta_q;
	logic rdy_sync_q;

	// ----------------------------------------------------------------
	// ready synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdy_meta_q <= 1'b1;
			rdy_sync_q <= 1'b1;
		end
		else
		begin
			rdy_meta_q <= port.host_ready_out;
			rdy_sync_q <= rdy_meta_q;
		end
	end

	assign cmd_ready = (state_q == HPC_HST_IDLE);

	// ----------------------------------------------------------------
	// access sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= HPC_HST_IDLE;
			cnt_q <= '0;
			strobe_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				HPC_HST_IDLE:
				begin
					if (cmd_valid)
					begin
						state_q <= HPC_HST_SETUP;
						cnt_q <= '0;
					end
				end
				HPC_HST_SETUP:
				begin
					// direction and function settle before the strobe edge
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q + 1'b1 >= HPC_CNT_W'(HPC_SETUP_CYC))
					begin
						state_q <= HPC_HST_STROBE;
						strobe_q <= 1'b1;
						cnt_q <= '0;
					end
				end
				HPC_HST_STROBE:
				begin
					// release only once ready has been high long enough
					if (!rdy_sync_q)
						cnt_q <= '0;
					else if (cnt_q != HPC_CNT_W'(HPC_RDY_HOLD_CYC))
						cnt_q <= cnt_q + 1'b1;
					if (rdy_sync_q && cnt_q == HPC_CNT_W'(HPC_RDY_HOLD_CYC)
						&& gap_q >= HPC_CNT_W'(HPC_STROBE_LOW_CYC))
					begin
						state_q <= HPC_HST_HOLD;
						strobe_q <= 1'b0;
						cnt_q <= '0;
					end
				end
				HPC_HST_HOLD:
				begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q + 1'b1 >= HPC_CNT_W'(HPC_FUNC_HOLD_CYC))
						state_q <= HPC_HST_GAP;
				end
				HPC_HST_GAP:
				begin
					cnt_q <= cnt_q + 1'b1;
					if (gap_q >= HPC_CNT_W'(HPC_SPACING_CYC)
						&& cnt_q >= HPC_CNT_W'(HPC_STROBE_HIGH_CYC))
						state_q <= HPC_HST_IDLE;
				end
				default:
				begin
					state_q <= HPC_HST_IDLE;
					strobe_q <= 1'b0;
				end
			endcase
		end
	end

	// time since the start of the last strobe, saturating
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			gap_q <= '1;
		else if (state_q == HPC_HST_SETUP && cnt_q + 1'b1 >= HPC_CNT_W'(HPC_SETUP_CYC))
			gap_q <= '0;
		else if (gap_q != '1)
			gap_q <= gap_q + 1'b1;
	end

	// ----------------------------------------------------------------
	// command capture and read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			write_q <= 1'b0;
			be_q <= '0;
			func_q <= '0;
			wdata_q <= '0;
		end
		else if (state_q == HPC_HST_IDLE && cmd_valid)
		begin
			write_q <= cmd_write;
			be_q <= cmd_be;
			func_q <= cmd_func;
			wdata_q <= cmd_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			if (state_q == HPC_HST_STROBE && !write_q && rdy_sync_q
				&& cnt_q == HPC_CNT_W'(HPC_RDY_HOLD_CYC) && gap_q >= HPC_CNT_W'(HPC_STROBE_LOW_CYC))
			begin
				rsp_valid <= 1'b1;
				rsp_rdata <= port.data_level;
			end
		end
	end

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	logic in_access;
	assign in_access = (state_q == HPC_HST_SETUP) || (state_q == HPC_HST_STROBE)
		|| (state_q == HPC_HST_HOLD);
	// never both request lines low at once
	assign port.host_write_req_n = !(in_access && write_q);
	assign port.host_read_req_n = !(in_access && !write_q);
	assign port.host_chip_select_n = !strobe_q;
	assign port.host_low_byte_strobe_n = !(strobe_q && be_q[0]);
	assign port.host_high_byte_strobe_n = !(strobe_q && be_q[1]);
	assign port.host_func_sel_0 = func_q[0];
	assign port.host_func_sel_1 = func_q[1];
	assign port.host_data_out = wdata_q;
	assign port.host_data_oe = in_access && write_q;
endmodule
`default_nettype wire

// File: hpc_dev.sv
// device end: decodes host port read and write cycles and drives ready and read data
`timescale 1ns/100ps
`default_nettype none
module hpc_dev
	import hpc_pkg::*;
#(
	parameter int DATA_W = HPC_DATA_W,
	parameter int SYNC_STAGES = HPC_SYNC_STAGES
)(
	input wire logic clk_sys,
	input wire logic rst_b,
	hpc_if.dev port,
	output logic acc_valid,
	output logic acc_write,
	output logic [HPC_FUNC_W-1:0] acc_func,
	output logic [HPC_BE_W-1:0] acc_be,
	output logic [DATA_W-1:0] acc_wdata,
	input wire logic acc_done,
	input wire logic [DATA_W-1:0] acc_rdata,
	output logic cyc_active
);
	initial
	begin
		if (SYNC_STAGES < 2)
			$error("hpc_dev: SYNC_STAGES must be at least 2");
		if (DATA_W < 8 || DATA_W % 8 != 0)
			$error("hpc_dev: DATA_W must be a whole number of bytes");
	end

	localparam int CTL_W = 7;
	localparam int IN_W = CTL_W + DATA_W;

	// strobe is the and of select, request and either byte lane, all active low
	function automatic logic strobe_on(input logic cs_n, input logic req_n,
		input logic lds_n, input logic uds_n);
		strobe_on = !cs_n && !req_n && (!lds_n || !uds_n);
	endfunction

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [IN_W-1:0] raw_in;
	logic [IN_W-1:0] sync_in;
	assign raw_in = {port.data_level, port.host_func_sel_1, port.host_func_sel_0,
		port.host_high_byte_strobe_n, port.host_low_byte_strobe_n,
		port.host_write_req_n, port.host_read_req_n, port.host_chip_select_n};

	genvar gi;
	generate
		for (gi = 0; gi < IN_W; gi++)
		begin : g_sync
			logic [SYNC_STAGES-1:0] chain_q;
			// control lines idle high, data bus pulled up
			always_ff @(posedge clk_sys or negedge rst_b)
			begin
				if (!rst_b)
					chain_q <= '1;
				else
					chain_q <= {chain_q[SYNC_STAGES-2:0], raw_in[gi]};
			end
			assign sync_in[gi] = chain_q[SYNC_STAGES-1];
		end
	endgenerate

	logic s_cs_n;
	logic s_rd_n;
	logic s_wr_n;
	logic s_lds_n;
	logic s_uds_n;
	logic [HPC_FUNC_W-1:0] s_func;
	logic [DATA_W-1:0] s_data;
	assign s_cs_n = sync_in[0];
	assign s_rd_n = sync_in[1];
	assign s_wr_n = sync_in[2];
	assign s_lds_n = sync_in[3];
	assign s_uds_n = sync_in[4];
	assign s_func = sync_in[6:5];
	assign s_data = sync_in[IN_W-1:CTL_W];

	// ----------------------------------------------------------------
	// cycle decode
	// ----------------------------------------------------------------
	logic wr_strobe;
	logic rd_strobe;
	logic any_strobe;
	logic any_strobe_q;
	logic cyc_start;
	assign wr_strobe = strobe_on(s_cs_n, s_wr_n, s_lds_n, s_uds_n);
	assign rd_strobe = strobe_on(s_cs_n, s_rd_n, s_lds_n, s_uds_n);
	// a select pulse without request or lane never forms a strobe
	assign any_strobe = wr_strobe || rd_strobe;
	// rising strobe is the last input to fall, falling is the first to rise
	assign cyc_start = any_strobe && !any_strobe_q;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			any_strobe_q <= 1'b0;
		else
			any_strobe_q <= any_strobe;
	end

	// ----------------------------------------------------------------
	// access sequencer
	// ----------------------------------------------------------------
	hpc_dev_state_e state_q;
	logic rdy_q;
	logic is_read_q;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= HPC_DEV_IDLE;
			rdy_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				HPC_DEV_IDLE:
				begin
					if (cyc_start)
						state_q <= HPC_DEV_WAIT;
				end
				HPC_DEV_WAIT:
				begin
					// wait length follows local bus contention, not a count
					if (acc_done)
					begin
						state_q <= HPC_DEV_DONE;
						rdy_q <= 1'b1;
					end
				end
				HPC_DEV_DONE:
				begin
					if (!any_strobe)
					begin
						state_q <= HPC_DEV_IDLE;
						rdy_q <= 1'b0;
					end
				end
				default:
				begin
					state_q <= HPC_DEV_IDLE;
					rdy_q <= 1'b0;
				end
			endcase
		end
	end

	assign cyc_active = (state_q != HPC_DEV_IDLE);

	// raw select gates ready so an idle select shows high at once;
	// a select glitch therefore passes straight through to ready
	assign port.host_ready_out = port.host_chip_select_n || rdy_q;

	// ----------------------------------------------------------------
	// local access request
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			acc_valid <= 1'b0;
			acc_write <= 1'b0;
			acc_func <= '0;
			acc_be <= '0;
			acc_wdata <= '0;
			is_read_q <= 1'b0;
		end
		else
		begin
			acc_valid <= 1'b0;
			if (state_q == HPC_DEV_IDLE && cyc_start)
			begin
				// write data is sampled through the same synchroniser as the strobe
				acc_valid <= 1'b1;
				acc_write <= wr_strobe;
				is_read_q <= rd_strobe;
				acc_func <= s_func;
				acc_be <= {!s_uds_n, !s_lds_n};
				acc_wdata <= s_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// read data drive
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] rdata_q;
	logic oe_q;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			rdata_q <= '0;
		else if (state_q == HPC_DEV_WAIT && acc_done)
			rdata_q <= acc_rdata;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			oe_q <= 1'b0;
		else
			oe_q <= is_read_q && rd_strobe
				&& (state_q == HPC_DEV_DONE || (state_q == HPC_DEV_WAIT && acc_done));
	end

	// raw read strobe cuts the drive at once when the host ends the cycle
	assign port.dev_data_oe = oe_q && strobe_on(port.host_chip_select_n,
		port.host_read_req_n, port.host_low_byte_strobe_n, port.host_high_byte_strobe_n);
	assign port.dev_data_out = rdata_q;
endmodule
`default_nettype wire

// File: hpc_sva.sv
// assertion checker on the host port pins between the host and device ends
`timescale 1ns/100ps
`default_nettype none
module hpc_sva
	import hpc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic host_chip_select_n,
	input wire logic host_read_req_n,
	input wire logic host_write_req_n,
	input wire logic host_low_byte_strobe_n,
	input wire logic host_high_byte_strobe_n,
	input wire logic host_func_sel_0,
	input wire logic host_func_sel_1,
	input wire logic host_ready_out,
	input wire logic dev_data_oe
);
	logic cs_q;
	logic [7:0] gap_q;
	logic lane_on;
	assign lane_on = !host_low_byte_strobe_n || !host_high_byte_strobe_n;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------------------------------
	// cycles since the last select fall, saturating so idle time never wraps
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cs_q <= 1'b1;
			gap_q <= 8'hFF;
		end
		else
		begin
			cs_q <= host_chip_select_n;
			if (cs_q && !host_chip_select_n)
				gap_q <= 8'h01;
			else if (gap_q != 8'hFF)
				gap_q <= gap_q + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_ready_deselect: assert property (host_chip_select_n |-> host_ready_out)
		else $error("ready low while deselected");
	a_ready_wait: assert property ($fell(host_chip_select_n) |-> !host_ready_out [*3])
		else $error("ready not held low after select fall");
	a_ready_held: assert property (($rose(host_ready_out) && !host_chip_select_n) |=>
		(host_ready_out || host_chip_select_n) [*4])
		else $error("ready dropped inside a cycle");
	a_oe_in_read: assert property (dev_data_oe |-> (!host_chip_select_n && !host_read_req_n
		&& host_write_req_n && lane_on))
		else $error("read data driven outside a read strobe");
	a_oe_after_ready: assert property ($rose(dev_data_oe) |-> host_ready_out)
		else $error("read data driven before ready");
	a_req_exclusive: assert property (host_read_req_n || host_write_req_n)
		else $error("read and write requests low together");
	a_ctrl_stable: assert property (!$past(host_chip_select_n) |-> $stable({host_func_sel_1,
		host_func_sel_0, host_read_req_n, host_write_req_n}))
		else $error("function or direction moved inside a strobe");
	a_strobe_gap: assert property ($fell(host_chip_select_n) |-> gap_q >= HPC_SPACING_CYC)
		else $error("strobe starts too close together");
endmodule
`default_nettype wire

// File: host_port_cycle_decode_tb.sv
// self-checking bench: host end and device end joined, plus a bench-driven device
`timescale 1ns/100ps
`default_nettype none
module host_port_cycle_decode_tb;
	import hpc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ready, rsp_valid;
	logic [1:0] cmd_func = 2'h0, cmd_be = 2'h0, acc_func, acc_be;
	logic [15:0] cmd_wdata = 16'h0, rsp_rdata, acc_wdata, acc_rdata = 16'h0, a2_wdata, rd_exp;
	logic acc_valid, acc_write, acc_done = 1'b0, cyc_active, a2_valid, a2_write, a2_done = 1'b0;
	logic [20:0] exp_e;
	logic [20:0] cmd_q[$];
	logic [15:0] rd_q[$];
	int n_mismatch = 0, n_tests = 0, a2_n = 0, dly, i, k;

	always #(HPC_CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

	hpc_if port_if();
	hpc_if fault_if();
	hpc_host hpc_host_inst (.clk_sys(clk_sys), .rst_b(rst_b), .port(port_if),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
		.cmd_func(cmd_func), .cmd_be(cmd_be), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
	hpc_dev hpc_dev_inst (.clk_sys(clk_sys), .rst_b(rst_b), .port(port_if),
		.acc_valid(acc_valid), .acc_write(acc_write), .acc_func(acc_func), .acc_be(acc_be),
		.acc_wdata(acc_wdata), .acc_done(acc_done), .acc_rdata(acc_rdata),
		.cyc_active(cyc_active));
	hpc_dev hpc_dev_fault_inst (.clk_sys(clk_sys), .rst_b(rst_b), .port(fault_if),
		.acc_valid(a2_valid), .acc_write(a2_write), .acc_func(), .acc_be(),
		.acc_wdata(a2_wdata), .acc_done(a2_done), .acc_rdata(16'h0000), .cyc_active());
	hpc_sva hpc_sva_inst (.clk_sys(clk_sys), .rst_b(rst_b),
		.host_chip_select_n(port_if.host_chip_select_n),
		.host_read_req_n(port_if.host_read_req_n),
		.host_write_req_n(port_if.host_write_req_n),
		.host_low_byte_strobe_n(port_if.host_low_byte_strobe_n),
		.host_high_byte_strobe_n(port_if.host_high_byte_strobe_n),
		.host_func_sel_0(port_if.host_func_sel_0), .host_func_sel_1(port_if.host_func_sel_1),
		.host_ready_out(port_if.host_ready_out), .dev_data_oe(port_if.dev_data_oe));

	// ----------------------------------------------------------------
	// compare and closing tasks
	// ----------------------------------------------------------------
	task automatic chk_val(input string name, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic chk_bit(input string name, input logic e, input logic g);
		chk_val(name, {15'h0000, e}, {15'h0000, g});
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic fpins(input logic [3:0] v);
		fault_if.host_chip_select_n = v[3];
		fault_if.host_read_req_n = v[2];
		fault_if.host_write_req_n = v[1];
		fault_if.host_low_byte_strobe_n = v[0];
	endtask

	// command is taken at the edge after cmd_ready is seen high;
	// valid rises only once the host is idle, never in the step it fell
	task automatic send(input logic w, input logic [1:0] be);
		k = 0;
		while (cmd_ready !== 1'b1 && k < 400)
		begin
			@(posedge clk_sys);
			#1 k++;
		end
		if (k >= 400)
		begin
			n_mismatch++;
			test_done();
		end
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_func = 2'($urandom);
		cmd_be = be;
		cmd_wdata = 16'($urandom);
		@(posedge clk_sys);
		#1 cmd_valid = 1'b0;
		cmd_q.push_back({w, cmd_func, be, cmd_wdata});
	endtask

	task automatic wait_n(input int n);
		k = 0;
		while (a2_n < n && k < 50)
		begin
			@(posedge clk_sys);
			k++;
		end
		if (a2_n < n)
		begin
			n_mismatch++;
			test_done();
		end
	endtask

	// ----------------------------------------------------------------
	// local side model: checks each decoded access, answers after a random wait
	// ----------------------------------------------------------------
	always
	begin
		@(posedge clk_sys);
		#1;
		if (acc_valid === 1'b1)
		begin
			exp_e = 'x;
			if (cmd_q.size() != 0)
				exp_e = cmd_q.pop_front();
			chk_bit("acc_write", exp_e[20], acc_write);
			chk_val("acc_func", {14'h0000, exp_e[19:18]}, {14'h0000, acc_func});
			chk_val("acc_be", {14'h0000, exp_e[17:16]}, {14'h0000, acc_be});
			chk_bit("cyc_active", 1'b1, cyc_active);
			if (exp_e[20] === 1'b1)
				chk_val("acc_wdata", exp_e[15:0], acc_wdata);
			dly = $urandom_range(6);
			repeat (dly)
			begin
				@(posedge clk_sys);
				#1;
			end
			acc_rdata = 16'($urandom);
			if (exp_e[20] === 1'b0)
				rd_q.push_back(acc_rdata);
			acc_done = 1'b1;
			@(posedge clk_sys);
			#1 acc_done = 1'b0;
		end
	end

	always
	begin
		@(posedge clk_sys);
		#1;
		if (rsp_valid === 1'b1)
		begin
			rd_exp = 'x;
			if (rd_q.size() != 0)
				rd_exp = rd_q.pop_front();
			chk_val("rsp_rdata", rd_exp, rsp_rdata);
		end
		if (a2_valid === 1'b1)
		begin
			a2_n++;
			chk_bit("fault acc_write", 1'b1, a2_write);
			chk_val("fault acc_wdata", 16'hA5C3, a2_wdata);
			a2_done = 1'b1;
			@(posedge clk_sys);
			#1 a2_done = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		fpins(4'hF);
		fault_if.host_high_byte_strobe_n = 1'b1;
		fault_if.host_func_sel_0 = 1'b0;
		fault_if.host_func_sel_1 = 1'b1;
		fault_if.host_data_out = 16'hA5C3;
		fault_if.host_data_oe = 1'b0;
		void'($urandom(97635));
		repeat (3) @(posedge clk_sys);
		#1 rst_b = 1'b1;
		// each nonzero lane code in both directions, then random back-to-back traffic
		for (i = 0; i < 6; i++)
			send(i[0], 2'(i / 2 + 1));
		for (i = 0; i < 10; i++)
			send(1'($urandom), 2'($urandom_range(3, 1)));
		k = 0;
		while ((cmd_q.size() != 0 || rd_q.size() != 0 || cmd_ready !== 1'b1) && k < 500)
		begin
			@(posedge clk_sys);
			#1 k++;
		end
		chk_bit("all answered", 1'b1, k < 500);
		// select alone opens no cycle; ready follows select
		fpins(4'h7);
		#1 chk_bit("ready select only", 1'b0, fault_if.host_ready_out);
		repeat (6) @(posedge clk_sys);
		#1 fpins(4'hF);
		#1 chk_bit("ready deselected", 1'b1, fault_if.host_ready_out);
		fault_if.host_chip_select_n = 1'b0;
		#1 fault_if.host_chip_select_n = 1'b1;
		repeat (6) @(posedge clk_sys);
		chk_val("cycles from select", 16'h0000, 16'(a2_n));
		// select falls last and opens the cycle; lane rises first and ends it
		#1 fault_if.host_data_oe = 1'b1;
		fpins(4'hD);
		@(posedge clk_sys);
		#1 fpins(4'hC);
		@(posedge clk_sys);
		#1 fpins(4'h4);
		wait_n(1);
		repeat (8) @(posedge clk_sys);
		#1 chk_bit("ready after done", 1'b1, fault_if.host_ready_out);
		fpins(4'h5);
		repeat (5) @(posedge clk_sys);
		#1 chk_bit("ready after end", 1'b0, fault_if.host_ready_out);
		repeat (45) @(posedge clk_sys);
		#1 fpins(4'h4);
		wait_n(2);
		repeat (8) @(posedge clk_sys);
		#1 fpins(4'hF);
		fault_if.host_data_oe = 1'b0;
		repeat (4) @(posedge clk_sys);
		chk_val("fault cycles", 16'h0002, 16'(a2_n));
		test_done();
	end
endmodule
`default_nettype wire
